// File: src/pere_top.sv
// port error rate enable, detect, counter, capture and interrupt over AHB-Lite
//
// Functional notes
// - errors count and capture only when enabled
// - software detect write counts enabled classes
// - threshold reach raises software notification
// - bit 0 enables vendor defined faults
// - vendor capture valid only certain kinds
// - bit 9 enables control symbol checksum faults
// - bit 10 enables acknowledge bad id
// - bit 11 enables refused acknowledge symbols
// - bit 12 enables packet bad id
// - bit 13 enables packet checksum faults
// - bit 14 enables oversize packets
// - bit 26 enables link reply bad id
// - bit 27 enables unexpected symbol faults
// - bit 29 enables framing faults
// - bit 30 enables stray acknowledge symbols
// - bit 31 enables reply timeouts
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module pere_top
    import pere_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic [1:0]             hresp,
    // fault reports from the port
    input  wire pere_fault_t       fault,
    // notification
    output logic                   irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]           rate_en;
        logic [31:0]           detect;
        logic [CNT_W-1:0]      cnt;
        logic [CNT_W-1:0]      thresh;
        logic [ERR_TYPE_W-1:0] capt_type;
        logic                  capt_valid;
        logic [31:0]           capt_data;
        logic [IRQ_W-1:0]      irq_stat;
        logic [IRQ_W-1:0]      irq_mask;
        logic                  irq;
        logic                  wr_pend;
        logic [IDX_W-1:0]      wr_idx;
        logic [31:0]           hrdata;
        logic                  hreadyout;
        logic [1:0]            hresp;
    } pere_state_t;

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    pere_state_t s_q;
    pere_state_t s_d;
    logic        rst_meta_q;
    logic        rst_sync_q;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // lowest numbered active class wins the capture slot
    function automatic logic [ERR_TYPE_W-1:0] first_class(input logic [31:0] v);
        logic [ERR_TYPE_W-1:0] r;
        r = '0;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = ERR_TYPE_W'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [31:0]      gate;
    logic [31:0]      hw_hit;
    logic [31:0]      sw_hit;
    logic             addr_ok;
    logic [IDX_W-1:0] rd_idx;
    logic             wr_now;
    logic             cnt_clr;
    logic             cnt_inc;
    logic             cnt_max;
    logic             thresh_hit;
    logic             capt_take;
    logic             info_ok;
    logic [31:0]      rd_val;

    always_comb begin
        s_d = s_q;

        // per class gating
        gate                = '0;
        gate[BIT_VENDOR]    = s_q.rate_en[BIT_VENDOR];
        gate[BIT_CTL_CRC]   = s_q.rate_en[BIT_CTL_CRC];
        gate[BIT_ACK_BADID] = s_q.rate_en[BIT_ACK_BADID];
        gate[BIT_REFUSED]   = s_q.rate_en[BIT_REFUSED];
        gate[BIT_PKT_BADID] = s_q.rate_en[BIT_PKT_BADID];
        gate[BIT_PKT_CSUM]  = s_q.rate_en[BIT_PKT_CSUM];
        gate[BIT_OVERSIZE]  = s_q.rate_en[BIT_OVERSIZE];
        gate[BIT_LR_BADID]  = s_q.rate_en[BIT_LR_BADID];
        gate[BIT_UNEXP_SYM] = s_q.rate_en[BIT_UNEXP_SYM];
        gate[BIT_FRAMING]   = s_q.rate_en[BIT_FRAMING];
        gate[BIT_STRAY_ACK] = s_q.rate_en[BIT_STRAY_ACK];
        gate[BIT_TIMEOUT]   = s_q.rate_en[BIT_TIMEOUT];

        // bus address phase
        addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
        rd_idx  = haddr[IDX_LSB +: IDX_W];
        wr_now  = s_q.wr_pend;

        hw_hit  = fault.flags & RATE_EN_MASK & gate;
        sw_hit  = (wr_now && s_q.wr_idx == IDX_DETECT) ? (hwdata & RATE_EN_MASK & gate) : '0;
        cnt_clr = wr_now && (s_q.wr_idx == IDX_COUNT);
        cnt_inc = (|hw_hit) || (|sw_hit);
        cnt_max = &s_q.cnt;

        // error rate counter, saturating
        if (cnt_clr) begin
            s_d.cnt = '0;
        end
        if (cnt_inc && !cnt_max) begin
            s_d.cnt = (cnt_clr ? '0 : s_q.cnt) + CNT_ONE;
        end
        thresh_hit = cnt_inc && !cnt_max && (s_q.thresh != '0)
                     && ((cnt_clr ? CNT_ONE : s_q.cnt + CNT_ONE) == s_q.thresh);

        // capture of the first enabled fault
        capt_take = (|hw_hit) && !s_q.capt_valid;
        info_ok   = 1'b1;
        if (first_class(hw_hit) == ERR_TYPE_W'(BIT_VENDOR)) begin
            info_ok = (fault.vd_kind == VD_RSVD_TRANSPORT)
                      || (fault.vd_kind == VD_UNMAPPED_DEST);
        end else if (|(hw_hit & NO_INFO_MASK & ~(hw_hit - 32'h1) & hw_hit)) begin
            info_ok = 1'b0;
        end

        // register writes in the data phase
        if (wr_now) begin
            case (s_q.wr_idx)
                IDX_RATE_EN: begin
                    s_d.rate_en = hwdata & RATE_EN_MASK;
                end
                IDX_DETECT: begin
                    s_d.detect = hwdata & RATE_EN_MASK;
                end
                IDX_THRESH: begin
                    s_d.thresh = hwdata[CNT_W-1:0];
                end
                IDX_CAPT_ATTR: begin
                    if (!hwdata[VAL_CAPT_BIT]) begin
                        s_d.capt_valid = 1'b0;
                    end
                end
                IDX_IRQ_STAT: begin
                    s_d.irq_stat = s_q.irq_stat & ~hwdata[IRQ_W-1:0];
                end
                IDX_IRQ_MASK: begin
                    s_d.irq_mask = hwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // hardware sets win over software clears
        s_d.detect = s_d.detect | (fault.flags & RATE_EN_MASK);
        if (capt_take) begin
            s_d.capt_type  = first_class(hw_hit);
            s_d.capt_data  = (first_class(hw_hit) == ERR_TYPE_W'(BIT_VENDOR)
                              && fault.vd_kind == VD_MAX_RETRY) ? fault.last_rx : fault.info;
            s_d.capt_valid = info_ok;
        end
        if (thresh_hit) begin
            s_d.irq_stat[IRQ_THRESH] = 1'b1;
        end
        if (capt_take && info_ok) begin
            s_d.irq_stat[IRQ_CAPT] = 1'b1;
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // read data prepared in the address phase
        case (rd_idx)
            IDX_RATE_EN:   rd_val = s_q.rate_en;
            IDX_DETECT:    rd_val = s_q.detect;
            IDX_COUNT:     rd_val = 32'(s_q.cnt);
            IDX_THRESH:    rd_val = 32'(s_q.thresh);
            IDX_CAPT_ATTR: rd_val = {s_q.capt_valid, 23'h000000, 3'h0, s_q.capt_type};
            IDX_CAPT_DATA: rd_val = s_q.capt_data;
            IDX_IRQ_STAT:  rd_val = 32'(s_q.irq_stat);
            IDX_IRQ_MASK:  rd_val = 32'(s_q.irq_mask);
            default:       rd_val = 32'h00000000;
        endcase
        s_d.hrdata    = (addr_ok && !hwrite) ? rd_val : 32'h00000000;
        s_d.wr_pend   = addr_ok && hwrite;
        s_d.wr_idx    = rd_idx;
        s_d.hreadyout = 1'b1;
        s_d.hresp     = HRESP_OKAY;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q            <= '0;
            s_q.rate_en    <= RATE_EN_RST;
            s_q.detect     <= DETECT_RST;
            s_q.hreadyout  <= 1'b1;
            s_q.hresp      <= HRESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata    = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp     = s_q.hresp;
    assign irq       = s_q.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_q);

    AST_GATED_COUNT: assert property (
        (((fault.flags & s_q.rate_en) == '0) && (sw_hit == '0) && !cnt_clr) |=> $stable(s_q.cnt)
    ) else $error("counter moved without an enabled error");

    AST_SW_DETECT_INC: assert property (
        (wr_now && s_q.wr_idx == IDX_DETECT && |(hwdata & s_q.rate_en) && !cnt_max)
        |=> (s_q.cnt == $past(s_q.cnt) + CNT_ONE)
    ) else $error("detect write with enabled bit did not count");

    AST_THRESH_NOTIFY: assert property (
        (cnt_inc && !cnt_max && !cnt_clr && s_q.thresh != '0 && s_q.cnt + CNT_ONE == s_q.thresh
         && s_q.irq_mask[IRQ_THRESH] && !(wr_now && s_q.wr_idx == IDX_IRQ_MASK))
        |=> (s_q.irq_stat[IRQ_THRESH] && irq)
    ) else $error("threshold reached without notification");

    AST_IRQ_LEVEL: assert property (
        irq == |(s_q.irq_stat & s_q.irq_mask)
    ) else $error("interrupt output disagrees with status and mask");

    AST_VENDOR_CLASS: assert property (
        (fault.flags[BIT_VENDOR] && s_q.rate_en[BIT_VENDOR] && !s_q.capt_valid
         && fault.vd_kind == VD_RSVD_TRANSPORT)
        |=> (s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_VENDOR))
    ) else $error("vendor fault not captured as class zero");

    AST_MAX_RETRY_DATA: assert property (
        (fault.flags[BIT_VENDOR] && s_q.rate_en[BIT_VENDOR] && !s_q.capt_valid
         && fault.vd_kind == VD_MAX_RETRY) |=> (s_q.capt_data == $past(fault.last_rx) && !s_q.capt_valid)
    ) else $error("retry fault captured wrong word or marked valid");

    AST_FRAMING_NO_INFO: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_FRAMING) && !s_q.capt_valid)
        ##1 (fault.flags == '0) [*2] |-> !s_q.capt_valid
    ) else $error("framing fault marked capture as valid");

    AST_CHECKSUM_COUNT: assert property (
        (fault.flags == (32'h1 << BIT_PKT_CSUM) && s_q.rate_en[BIT_PKT_CSUM] && !cnt_max
         && !cnt_clr && sw_hit == '0) |=> (s_q.cnt == $past(s_q.cnt) + CNT_ONE)
    ) else $error("enabled packet checksum fault not counted");

    AST_RESERVED_ZERO: assert property (
        ((s_q.rate_en & ~RATE_EN_MASK) == '0) && ((s_q.detect & ~RATE_EN_MASK) == '0)
    ) else $error("reserved enable or detect bit set");

    AST_DISABLED_TIMEOUT: assert property (
        (fault.flags == (32'h1 << BIT_TIMEOUT) && !s_q.rate_en[BIT_TIMEOUT] && !s_q.capt_valid)
        |=> !s_q.capt_valid
    ) else $error("disabled timeout reached capture");

    AST_CAPT_HELD: assert property (
        (s_q.capt_valid && !(wr_now && s_q.wr_idx == IDX_CAPT_ATTR))
        |=> ($stable(s_q.capt_data) && $stable(s_q.capt_type) && s_q.capt_valid)
    ) else $error("locked capture changed");

    AST_DISABLED_NO_CAPT: assert property (
        (((fault.flags & s_q.rate_en) == '0) && !s_q.capt_valid)
        |=> !s_q.capt_valid
    ) else $error("capture taken without an enabled error");

    AST_LINK_REPLY_NO_INFO: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_LR_BADID) && !s_q.capt_valid)
        |=> (!s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_LR_BADID))
    ) else $error("link reply fault captured wrongly");

    AST_TIMEOUT_NO_INFO: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_TIMEOUT) && !s_q.capt_valid)
        |=> (!s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_TIMEOUT))
    ) else $error("timeout fault captured wrongly");

    AST_UNEXP_SYM_VALID: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_UNEXP_SYM) && !s_q.capt_valid)
        |=> (s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_UNEXP_SYM))
    ) else $error("unexpected symbol fault not captured as valid");

    AST_PKT_BADID_VALID: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_PKT_BADID) && !s_q.capt_valid)
        |=> (s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_PKT_BADID))
    ) else $error("packet bad id fault not captured as valid");

    AST_STRAY_ACK_VALID: assert property (
        ((fault.flags & RATE_EN_MASK & s_q.rate_en) == (32'h1 << BIT_STRAY_ACK) && !s_q.capt_valid)
        |=> (s_q.capt_valid && s_q.capt_type == ERR_TYPE_W'(BIT_STRAY_ACK))
    ) else $error("stray acknowledge fault not captured as valid");

    AST_VALID_HAS_INFO: assert property (
        s_q.capt_valid |-> !NO_INFO_MASK[s_q.capt_type]
    ) else $error("capture valid for a class without information");

    AST_DETECT_RECORDS: assert property (
        fault.flags[BIT_CTL_CRC] |=> s_q.detect[BIT_CTL_CRC]
    ) else $error("control symbol checksum fault not recorded");

    AST_THRESH_CLEAR: assert property (
        (wr_now && s_q.wr_idx == IDX_IRQ_STAT && hwdata[IRQ_THRESH] && !thresh_hit)
        |=> !s_q.irq_stat[IRQ_THRESH]
    ) else $error("threshold status not cleared by write");

    AST_RATE_EN_READ: assert property (
        (addr_ok && !hwrite && rd_idx == IDX_RATE_EN) |=> (hrdata == $past(s_q.rate_en))
    ) else $error("enable register read back wrong");

    AST_UNMAPPED_ZERO: assert property (
        (addr_ok && !hwrite && rd_idx > IDX_IRQ_MASK) |=> (hrdata == 32'h00000000)
    ) else $error("unmapped register read not zero");

    AST_BUS_READY: assert property (
        hreadyout && (hresp == HRESP_OKAY)
    ) else $error("bus not ready or not okay");

    COV_THRESH: cover property (thresh_hit ##1 irq);
    COV_CAPT_VALID: cover property (capt_take && info_ok);
    COV_SW_INJECT: cover property (|sw_hit);
    COV_SET_CLEAR: cover property (wr_now && s_q.wr_idx == IDX_IRQ_STAT && thresh_hit);
    COV_NO_INFO: cover property (capt_take && !info_ok);

endmodule

`default_nettype wire

// File: shared/pere_pkg.sv
// constants and types shared by the port error rate enable block
package pere_pkg;

    // ----------------------------------------------------------------
    // bus and register map
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned IDX_LSB       = 2;
    localparam int unsigned IDX_W         = 6;
    localparam logic [5:0]  IDX_RATE_EN   = 6'h00;
    localparam logic [5:0]  IDX_DETECT    = 6'h01;
    localparam logic [5:0]  IDX_COUNT     = 6'h02;
    localparam logic [5:0]  IDX_THRESH    = 6'h03;
    localparam logic [5:0]  IDX_CAPT_ATTR = 6'h04;
    localparam logic [5:0]  IDX_CAPT_DATA = 6'h05;
    localparam logic [5:0]  IDX_IRQ_STAT  = 6'h06;
    localparam logic [5:0]  IDX_IRQ_MASK  = 6'h07;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HRESP_OKAY    = 2'h0;

    // ----------------------------------------------------------------
    // enable bit positions, one per error class
    // ----------------------------------------------------------------
    localparam int unsigned BIT_VENDOR    = 0;
    localparam int unsigned BIT_CTL_CRC   = 9;
    localparam int unsigned BIT_ACK_BADID = 10;
    localparam int unsigned BIT_REFUSED   = 11;
    localparam int unsigned BIT_PKT_BADID = 12;
    localparam int unsigned BIT_PKT_CSUM  = 13;
    localparam int unsigned BIT_OVERSIZE  = 14;
    localparam int unsigned BIT_LR_BADID  = 26;
    localparam int unsigned BIT_UNEXP_SYM = 27;
    localparam int unsigned BIT_FRAMING   = 29;
    localparam int unsigned BIT_STRAY_ACK = 30;
    localparam int unsigned BIT_TIMEOUT   = 31;
    localparam logic [31:0] RATE_EN_MASK  = 32'hec007e01;
    localparam logic [31:0] NO_INFO_MASK  = 32'ha4000000;
    localparam logic [31:0] RATE_EN_RST   = 32'h00000000;
    localparam logic [31:0] DETECT_RST    = 32'h00000000;

    // ----------------------------------------------------------------
    // capture attribute and interrupt layout
    // ----------------------------------------------------------------
    localparam int unsigned ERR_TYPE_W    = 5;
    localparam int unsigned VAL_CAPT_BIT  = 31;
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_THRESH    = 0;
    localparam int unsigned IRQ_CAPT      = 1;

    // kinds of vendor defined logical or transport fault
    typedef enum logic [2:0] {
        VD_RSVD_TRANSPORT,
        VD_MAX_RETRY,
        VD_UNMAPPED_DEST,
        VD_LOOKUP_PARITY,
        VD_OTHER
    } pere_vd_kind_t;

    // fault report from the port logic, one cycle per event
    typedef struct packed {
        logic [31:0]   flags;
        pere_vd_kind_t vd_kind;
        logic [31:0]   info;
        logic [31:0]   last_rx;
    } pere_fault_t;

endpackage

// File: verif/pere_link_partner.sv
// behavioural serial link partner that raises port fault reports
`timescale 1ns/1ns
`default_nettype none

module pere_link_partner
    import pere_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // command from the bench
    input  wire logic        send,
    input  wire pere_fault_t ev,
    // fault report towards the port
    output var  pere_fault_t fault
);
    // ----------------------------------------------------------------
    // one-cycle flags; info and last_rx invert between events
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault <= '0;
        end else if (send) begin
            fault <= ev;
        end else begin
            fault.flags   <= 32'h00000000;
            fault.info    <= ~fault.info;
            fault.last_rx <= ~fault.last_rx;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the port error rate enable block
`timescale 1ns/1ns
`default_nettype none

module tb;
    import pere_pkg::*;

    logic        clock;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [1:0]  hresp;
    logic        irq;
    logic        send;
    pere_fault_t ev;
    pere_fault_t fault;
    int          num_errors;
    int          check_count;
    int          bits [12] = '{0, 9, 10, 11, 12, 13, 14, 26, 27, 29, 30, 31};

    assign hready = hreadyout;

    pere_top u_pere_top (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fault(fault), .irq(irq));

    pere_link_partner u_pere_link_partner (.clock(clock), .rst_n(rst_n), .send(send), .ev(ev),
        .fault(fault));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, idx, 32'h00000000, r);
        chk(r, exp);
    endtask

    task automatic pulse(input logic [31:0] f, input pere_vd_kind_t k, input logic [31:0] i,
                         input logic [31:0] l);
        @(posedge clock);
        send <= 1'b1;
        ev   <= '{flags: f, vd_kind: k, info: i, last_rx: l};
        @(posedge clock);
        send <= 1'b0;
        @(posedge clock);
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; send = 1'b0; ev = '0;
        num_errors = 0; check_count = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
        rd(IDX_RATE_EN, RATE_EN_RST);
        wr(IDX_RATE_EN, 32'hffffffff);
        rd(IDX_RATE_EN, 32'hec007e01);
        wr(6'h20, 32'h12345678);
        rd(6'h20, 32'h00000000);
        // each enable gates only its own class
        foreach (bits[n]) begin
            wr(IDX_RATE_EN, 32'h1 << bits[n]);
            wr(IDX_COUNT, 32'h0);
            pulse(RATE_EN_MASK & ~(32'h1 << bits[n]), VD_OTHER, 32'h0, 32'h0);
            rd(IDX_COUNT, 32'h0);
            wr(IDX_CAPT_ATTR, 32'h0);
            pulse(32'h1 << bits[n], VD_OTHER, 32'h0, 32'h0);
            rd(IDX_COUNT, 32'h1);
            rd(IDX_CAPT_ATTR, {(bits[n] != BIT_VENDOR) && !NO_INFO_MASK[bits[n]], 26'h0, 5'(bits[n])});
        end
        // software detect writes
        wr(IDX_RATE_EN, 32'h1 << BIT_CTL_CRC);
        wr(IDX_COUNT, 32'h0);
        wr(IDX_DETECT, 32'h1 << BIT_ACK_BADID);
        rd(IDX_COUNT, 32'h0);
        wr(IDX_DETECT, 32'h1 << BIT_CTL_CRC);
        rd(IDX_COUNT, 32'h1);
        // threshold notification, mask and clear
        wr(IDX_IRQ_STAT, 32'h3);
        wr(IDX_RATE_EN, 32'h1 << BIT_PKT_CSUM);
        wr(IDX_COUNT, 32'h0);
        wr(IDX_THRESH, 32'h2);
        wr(IDX_IRQ_MASK, 32'h1);
        pulse(32'h1 << BIT_PKT_CSUM, VD_OTHER, 32'h0, 32'h0);
        chk_irq(1'b0);
        pulse(32'h1 << BIT_PKT_CSUM, VD_OTHER, 32'h0, 32'h0);
        chk_irq(1'b1);
        rd(IDX_IRQ_STAT, (32'h1 << IRQ_THRESH) | (32'h1 << IRQ_CAPT));
        wr(IDX_IRQ_MASK, 32'h0);
        chk_irq(1'b0);
        wr(IDX_IRQ_MASK, 32'h1);
        chk_irq(1'b1);
        wr(IDX_IRQ_STAT, 32'h1);
        chk_irq(1'b0);
        // vendor defined capture validity
        wr(IDX_THRESH, 32'h0);
        wr(IDX_CAPT_ATTR, 32'h0);
        wr(IDX_RATE_EN, 32'h1 << BIT_VENDOR);
        pulse(32'h1, VD_MAX_RETRY, 32'h11111111, 32'h22222222);
        rd(IDX_CAPT_ATTR, 32'h00000000);
        rd(IDX_CAPT_DATA, 32'h22222222);
        pulse(32'h1, VD_UNMAPPED_DEST, 32'h33333333, 32'h44444444);
        rd(IDX_CAPT_ATTR, 32'h80000000);
        rd(IDX_CAPT_DATA, 32'h33333333);
        wr(IDX_CAPT_ATTR, 32'h0);
        pulse(32'h1, VD_RSVD_TRANSPORT, 32'h66666666, 32'h77777777);
        rd(IDX_CAPT_ATTR, 32'h80000000);
        rd(IDX_CAPT_DATA, 32'h66666666);
        wr(IDX_CAPT_ATTR, 32'h0);
        wr(IDX_RATE_EN, 32'h0);
        pulse(32'h1, VD_RSVD_TRANSPORT, 32'h55555555, 32'h0);
        rd(IDX_CAPT_ATTR, 32'h00000000);
        pulse(32'h1 << BIT_TIMEOUT, VD_OTHER, 32'h0, 32'h0);
        rd(IDX_CAPT_ATTR, 32'h00000000);
        rd(IDX_COUNT, 32'h5);
        report_and_stop();
    end
endmodule
`default_nettype wire
